// file: dmade_addr_calc.sv
// Address generator for one side of a transfer: end pointer minus the
// remaining count scaled by the increment, or the end pointer when fixed.
// Assumes the caller holds all inputs stable while it uses the result.
`timescale 1ns/100ps
`default_nettype none
`include "dmade_defines.svh"

module dmade_addr_calc #(
  parameter int CNT_W = 10
) (
  input  wire logic [31:0]      end_ptr,
  input  wire logic [1:0]       data_size,
  input  wire logic [1:0]       inc_code,
  input  wire logic [CNT_W-1:0] remaining,
  output logic      [31:0]      addr,
  output logic                  reserved
);

  logic [31:0] span;
  logic        fixed;

  // An increment narrower than the data width has no meaning, nor has size 11.
  assign fixed    = (inc_code == `DMADE_INC_FIXED);
  assign reserved = (data_size == `DMADE_SIZE_RSVD) |
                    (~fixed & (inc_code < data_size));
  assign span     = 32'(remaining) << inc_code;
  assign addr     = fixed ? end_ptr : end_ptr - span;

endmodule // dmade_addr_calc

`default_nettype wire

// file: dmade_core.sv
// Descriptor fetch, transfer and error handling engine of a DMA channel
// group, with its APB register file and an AHB-Lite master port.
// Assumes the AHB-Lite slave and the APB master run on pclk.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "dmade_defines.svh"

module dmade_core #(
  parameter int NCH = 8
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  // APB slave.
  input  wire logic [7:0]      paddr,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // AHB-Lite master.
  output logic      [31:0]     haddr,
  output logic      [1:0]      htrans,
  output logic                 hwrite,
  output logic      [2:0]      hsize,
  output logic      [2:0]      hburst,
  output logic      [3:0]      hprot,
  output logic      [31:0]     hwdata,
  input  wire logic [31:0]     hrdata,
  input  wire logic            hready,
  input  wire logic            hresp,
  // Channel events.
  output logic      [NCH-1:0]  channel_done,
  output logic                 transfer_error
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [23:0]             descriptor_base;
  logic [NCH-1:0]          channel_enable_status;
  logic [NCH-1:0]          sw_request;
  logic [NCH-1:0]          done_flags;
  logic [1:0]              error_flags;
  dmade_pkg::dmade_state_e state;
  dmade_pkg::dmade_step_e  step;
  logic [2:0]              chan;
  logic [31:0]             src_end;
  logic [31:0]             dst_end;
  logic [31:0]             cfg;
  logic [9:0]              idx;
  logic [31:0]             data_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.

  // Every access completes after one wait-free access cycle.
  logic        apb_setup;
  logic        apb_wr;
  logic        hit_status;
  logic        hit_base;
  logic        hit_alt;
  logic        hit_req;
  logic        hit_set;
  logic        hit_clr;
  logic        hit_done;
  logic        hit_err;
  logic        mapped;
  logic [31:0] alternate_descriptor_base;
  logic [31:0] status_word;
  logic [31:0] rd_val;

  assign apb_setup  = psel & ~penable;
  assign apb_wr     = psel & penable & pwrite & pready;
  assign hit_status = (paddr == `DMADE_OFS_STATUS);
  assign hit_base   = (paddr == `DMADE_OFS_DESC_BASE);
  assign hit_alt    = (paddr == `DMADE_OFS_ALT_BASE);
  assign hit_req    = (paddr == `DMADE_OFS_SW_REQ);
  assign hit_set    = (paddr == `DMADE_OFS_CHEN_SET);
  assign hit_clr    = (paddr == `DMADE_OFS_CHEN_CLR);
  assign hit_done   = (paddr == `DMADE_OFS_DONE);
  assign hit_err    = (paddr == `DMADE_OFS_ERROR);
  assign mapped     = hit_status | hit_base | hit_alt | hit_req | hit_set |
                      hit_clr | hit_done | hit_err;

  // The alternate structure sits right above the primary one.
  assign alternate_descriptor_base = {descriptor_base, `DMADE_ALT_LOW_BYTE};
  assign status_word = {25'h0, chan, 3'h0, (state != dmade_pkg::dmade_idle)};

  // Read mux; write-only and unmapped words read as zero.
  assign rd_val = hit_status ? status_word :
                  hit_base   ? {descriptor_base, 8'h00} :
                  hit_alt    ? alternate_descriptor_base :
                  hit_req    ? 32'(sw_request) :
                  hit_set    ? 32'(channel_enable_status) :
                  hit_done   ? 32'(done_flags) :
                  hit_err    ? {30'h0, error_flags} : 32'h0;

  // Read data and the slave error are captured in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= apb_setup ? rd_val : 32'h0;
      pready  <= apb_setup;
      pslverr <= apb_setup & ~mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Engine decode.

  logic [NCH-1:0] pending;
  logic           pick_valid;
  logic [2:0]     pick;
  logic [9:0]     nm1;
  logic [9:0]     remaining;
  logic [31:0]    src_addr;
  logic [31:0]    dst_addr;
  logic           src_rsvd;
  logic           dst_rsvd;
  logic           beat_done;
  logic           bus_err;
  logic           cfg_err;
  logic           fin_ok;
  logic           kill;
  logic [NCH-1:0] chan_vec;
  logic [NCH-1:0] kill_vec;
  logic [31:0]    desc_addr;
  logic [3:0]     elem;
  logic [31:0]    rd_lane;
  logic [31:0]    wr_rep;

  assign pending = channel_enable_status & sw_request;

  // Lowest enabled channel with a request is served first.
  always_comb begin
    pick_valid = 1'b0;
    pick       = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (pending[i]) begin
        pick_valid = 1'b1;
        pick       = 3'(i);
      end
    end
  end

  // All transfer settings come from the fetched control word.
  assign nm1       = cfg[`DMADE_CFG_NM1];
  assign remaining = nm1 - idx;

  dmade_addr_calc #(
    .CNT_W (10)
  ) u_src_addr (
    .end_ptr   (src_end),
    .data_size (cfg[`DMADE_CFG_SRC_SIZE]),
    .inc_code  (cfg[`DMADE_CFG_SRC_INC]),
    .remaining (remaining),
    .addr      (src_addr),
    .reserved  (src_rsvd)
  );

  // Destination step is judged against the source width.
  dmade_addr_calc #(
    .CNT_W (10)
  ) u_dst_addr (
    .end_ptr   (dst_end),
    .data_size (cfg[`DMADE_CFG_SRC_SIZE]),
    .inc_code  (cfg[`DMADE_CFG_DST_INC]),
    .remaining (remaining),
    .addr      (dst_addr),
    .reserved  (dst_rsvd)
  );

  // Descriptor words: base, primary select, channel, element; 0xC never formed.
  assign elem      = (step == dmade_pkg::dmade_step_src) ? `DMADE_ELEM_SRC :
                     (step == dmade_pkg::dmade_step_dst) ? `DMADE_ELEM_DST :
                     `DMADE_ELEM_CFG;
  assign desc_addr = {descriptor_base, `DMADE_SEL_PRIMARY, chan, elem};

  assign beat_done = (state == dmade_pkg::dmade_data) & hready;
  assign bus_err   = beat_done & (hresp == `DMADE_HRESP_ERROR);
  assign cfg_err   = (state == dmade_pkg::dmade_prep) & (src_rsvd | dst_rsvd) &
                     ((step == dmade_pkg::dmade_step_read) |
                      (step == dmade_pkg::dmade_step_write));
  assign fin_ok    = beat_done & ~bus_err & (step == dmade_pkg::dmade_step_write) &
                     (idx == nm1);
  assign kill      = bus_err | cfg_err | fin_ok;
  assign chan_vec  = NCH'(1) << chan;
  assign kill_vec  = kill ? chan_vec : '0;

  // Byte lanes: pick the source lane, then copy it into every lane of the write.
  assign rd_lane = hrdata >> {haddr[1:0], 3'h0};
  assign wr_rep  = (hsize[1:0] == `DMADE_SIZE_BYTE) ? {4{data_q[7:0]}} :
                   (hsize[1:0] == `DMADE_SIZE_HALF) ? {2{data_q[15:0]}} : data_q;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers. Hardware disable beats a software enable in the same
  // cycle so a failed channel cannot slip back on; flag sets beat clears.

  logic [NCH-1:0] next_done_flags;
  logic [1:0]     next_error_flags;
  logic [1:0]     err_set;

  assign err_set          = {cfg_err, bus_err};
  assign next_done_flags  = (done_flags & ~((apb_wr & hit_done) ? pwdata[NCH-1:0] : '0)) |
                            (fin_ok ? chan_vec : '0);
  assign next_error_flags = (error_flags & ~((apb_wr & hit_err) ? pwdata[1:0] : 2'h0)) |
                            err_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      descriptor_base <= 24'h0;
    end else if (apb_wr & hit_base) begin
      descriptor_base <= pwdata[31:`DMADE_BASE_LSB];
    end
  end

  // Enable and request bits drop when the channel completes or fails.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_enable_status <= '0;
      sw_request            <= '0;
    end else begin
      channel_enable_status <= (channel_enable_status |
                                ((apb_wr & hit_set) ? pwdata[NCH-1:0] : '0)) &
                               ~((apb_wr & hit_clr) ? pwdata[NCH-1:0] : '0) &
                               ~kill_vec;
      sw_request            <= (sw_request | ((apb_wr & hit_req) ? pwdata[NCH-1:0] : '0)) &
                               ~kill_vec;
    end
  end

  // Sticky flags and the outputs that report them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flags     <= '0;
      error_flags    <= 2'h0;
      transfer_error <= 1'b0;
      channel_done   <= '0;
    end else begin
      done_flags     <= next_done_flags;
      error_flags    <= next_error_flags;
      transfer_error <= |next_error_flags;
      channel_done   <= fin_ok ? chan_vec : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Engine state machine. One beat at a time: prepare, address, data.
  // Descriptor words are only read; the engine never writes the descriptor.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= dmade_pkg::dmade_idle;
      step  <= dmade_pkg::dmade_step_src;
      chan  <= 3'h0;
      idx   <= 10'h0;
    end else begin
      case (state)
        dmade_pkg::dmade_idle: begin
          if (pick_valid) begin
            chan  <= pick;
            step  <= dmade_pkg::dmade_step_src;
            idx   <= 10'h0;
            state <= dmade_pkg::dmade_prep;
          end
        end
        dmade_pkg::dmade_prep: begin
          state <= cfg_err ? dmade_pkg::dmade_idle : dmade_pkg::dmade_addr;
        end
        dmade_pkg::dmade_addr: begin
          if (hready) begin
            state <= dmade_pkg::dmade_data;
          end
        end
        dmade_pkg::dmade_data: begin
          if (hready) begin
            state <= (bus_err | fin_ok) ? dmade_pkg::dmade_idle : dmade_pkg::dmade_prep;
            case (step)
              dmade_pkg::dmade_step_src:  step <= dmade_pkg::dmade_step_dst;
              dmade_pkg::dmade_step_dst:  step <= dmade_pkg::dmade_step_cfg;
              dmade_pkg::dmade_step_cfg:  step <= dmade_pkg::dmade_step_read;
              dmade_pkg::dmade_step_read: step <= dmade_pkg::dmade_step_write;
              default: begin
                step <= dmade_pkg::dmade_step_read;
                idx  <= idx + 10'h1;
              end
            endcase
          end
        end
        default: state <= dmade_pkg::dmade_idle;
      endcase
    end
  end

  // Captured read data: descriptor words and the source datum.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_end <= 32'h0;
      dst_end <= 32'h0;
      cfg     <= 32'h0;
      data_q  <= 32'h0;
    end else if (beat_done & ~bus_err) begin
      if (step == dmade_pkg::dmade_step_src) src_end <= hrdata;
      if (step == dmade_pkg::dmade_step_dst) dst_end <= hrdata;
      if (step == dmade_pkg::dmade_step_cfg) cfg <= hrdata;
      if (step == dmade_pkg::dmade_step_read) data_q <= rd_lane;
    end
  end

  // Bus request: set up in prepare, dropped once the address is taken.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      haddr  <= 32'h0;
      htrans <= `DMADE_HTRANS_IDLE;
      hwrite <= 1'b0;
      hsize  <= {1'b0, `DMADE_SIZE_WORD};
      hwdata <= 32'h0;
    end else if ((state == dmade_pkg::dmade_prep) & ~cfg_err) begin
      htrans <= `DMADE_HTRANS_NONSEQ;
      hwrite <= (step == dmade_pkg::dmade_step_write);
      hsize  <= (step >= dmade_pkg::dmade_step_read) ?
                {1'b0, cfg[`DMADE_CFG_SRC_SIZE]} : {1'b0, `DMADE_SIZE_WORD};
      haddr  <= (step == dmade_pkg::dmade_step_read)  ? src_addr :
                (step == dmade_pkg::dmade_step_write) ? dst_addr : desc_addr;
    end else if ((state == dmade_pkg::dmade_addr) & hready) begin
      htrans <= `DMADE_HTRANS_IDLE;
      hwdata <= wr_rep;
    end
  end

  // Single beats only, plain data access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hburst <= `DMADE_HBURST_SINGLE;
      hprot  <= `DMADE_HPROT_DATA;
    end else begin
      hburst <= `DMADE_HBURST_SINGLE;
      hprot  <= `DMADE_HPROT_DATA;
    end
  end

endmodule // dmade_core

`default_nettype wire

// file: dmade_defines.svh
// Constants of the descriptor-addressing and error block: register offsets,
// descriptor field positions, encodings and AHB-Lite codes.
// Assumes inclusion by its bare name from the block's design files.
`ifndef DMADE_DEFINES_SVH
`define DMADE_DEFINES_SVH

// Register offsets on the APB side (byte addresses, one word each).
`define DMADE_OFS_STATUS     8'h00
`define DMADE_OFS_DESC_BASE  8'h08
`define DMADE_OFS_ALT_BASE   8'h0c
`define DMADE_OFS_SW_REQ     8'h10
`define DMADE_OFS_CHEN_SET   8'h18
`define DMADE_OFS_CHEN_CLR   8'h1c
`define DMADE_OFS_DONE       8'h20
`define DMADE_OFS_ERROR      8'h24

// Descriptor structure addressing.
`define DMADE_BASE_LSB       8
`define DMADE_SEL_PRIMARY    1'b0
`define DMADE_ALT_LOW_BYTE   8'h80
`define DMADE_ELEM_SRC       4'h0
`define DMADE_ELEM_DST       4'h4
`define DMADE_ELEM_CFG       4'h8

// Control word fields.
`define DMADE_CFG_DST_INC    31:30
`define DMADE_CFG_SRC_INC    27:26
`define DMADE_CFG_SRC_SIZE   25:24
`define DMADE_CFG_NM1        13:4

// Width and increment encodings.
`define DMADE_SIZE_BYTE      2'h0
`define DMADE_SIZE_HALF      2'h1
`define DMADE_SIZE_WORD      2'h2
`define DMADE_SIZE_RSVD      2'h3
`define DMADE_INC_FIXED      2'h3

// Error flag positions.
`define DMADE_ERR_BUS        0
`define DMADE_ERR_CFG        1

// AHB-Lite codes.
`define DMADE_HTRANS_IDLE    2'h0
`define DMADE_HTRANS_NONSEQ  2'h2
`define DMADE_HBURST_SINGLE  3'h0
`define DMADE_HPROT_DATA     4'h1
`define DMADE_HRESP_ERROR    1'b1

`endif

// file: dmade_mem.sv
// Behavioural AHB-Lite memory answering the block's master port.
// Assumes single transfers within the low 4 KB; the bench steers stalls and errors.
`timescale 1ns/100ps
`default_nettype none

module dmade_mem (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        slow,
  input  wire logic [31:0] err_addr,
  output logic      [31:0] hrdata,
  output logic             hready,
  output logic             hresp
);
  logic [31:0] mem [0:1023];
  logic [9:0]  idx;
  logic        act, wr, er, wt;

  // Every word holds four equal bytes, so any lane reads the same value.
  initial begin
    for (int k = 0; k < 1024; k++) begin
      mem[k] = {4{8'(k) ^ 8'h5a}};
    end
  end

  // A stall or an error costs one low-ready cycle; outside a read the data
  // lines show the inverse, since a stale value could hide a late sample.
  assign hready = !act || wt || !(slow || er);
  assign hresp  = act && er;
  assign hrdata = (act && !wr && hready) ? mem[idx] : ~mem[idx];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act <= 1'b0;
      wr  <= 1'b0;
      er  <= 1'b0;
      wt  <= 1'b0;
    end else begin
      if (act && hready && wr && !er) begin
        mem[idx] <= hwdata;
      end
      if (hready) begin
        act <= htrans[1];
        wr  <= hwrite;
        er  <= haddr == err_addr;
        idx <= haddr[11:2];
        wt  <= 1'b0;
      end else begin
        wt <= 1'b1;
      end
    end
  end
endmodule // dmade_mem
`default_nettype wire

// file: dmade_pkg.sv
// Types shared by the descriptor-addressing and error block.
// Assumes nothing beyond a SystemVerilog compiler.
package dmade_pkg;

  // Engine state, one-hot.
  typedef enum logic [3:0] {
    dmade_idle = 4'h1,
    dmade_prep = 4'h2,
    dmade_addr = 4'h4,
    dmade_data = 4'h8
  } dmade_state_e;

  // Which word the current bus beat moves.
  typedef enum logic [2:0] {
    dmade_step_src   = 3'h0,
    dmade_step_dst   = 3'h1,
    dmade_step_cfg   = 3'h2,
    dmade_step_read  = 3'h3,
    dmade_step_write = 3'h4
  } dmade_step_e;

endpackage

// file: dmade_sva.sv
// Concurrent checks on the ports of the descriptor and error block.
// Assumes one pclk domain with presetn as its asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
`include "dmade_defines.svh"

module dmade_sva #(
  parameter int NCH = 8
) (
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic [7:0]     paddr,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [31:0]    pwdata,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  input wire logic [31:0]    haddr,
  input wire logic [1:0]     htrans,
  input wire logic           hwrite,
  input wire logic [2:0]     hsize,
  input wire logic [2:0]     hburst,
  input wire logic [3:0]     hprot,
  input wire logic [31:0]    hwdata,
  input wire logic [31:0]    hrdata,
  input wire logic           hready,
  input wire logic           hresp,
  input wire logic [NCH-1:0] channel_done,
  input wire logic           transfer_error
);
  // Shadow of the descriptor base, so bus addresses can be placed in the area.
  logic [31:8] base_q;
  wire         acc = psel && penable && pready;
  wire         nsq = htrans == `DMADE_HTRANS_NONSEQ && hready;
  wire         dsc = nsq && haddr[31:8] == base_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_q <= '0;
    end else if (acc && pwrite && paddr == `DMADE_OFS_DESC_BASE) begin
      base_q <= pwdata[31:8];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_err_raise: assert property (hready && hresp |=> transfer_error)
    else $error("bus error did not raise the error output");
  a_err_hold: assert property (transfer_error &&
    !(acc && pwrite && paddr == `DMADE_OFS_ERROR) |=> transfer_error)
    else $error("error output fell without a clearing write");
  a_done_pulse: assert property (|channel_done |=> channel_done == '0)
    else $error("completion output longer than one cycle");
  a_desc_elem: assert property (dsc |-> haddr[3:0] inside {4'h0, 4'h4, 4'h8})
    else $error("descriptor access to an unknown element");
  a_desc_no_fourth: assert property (dsc |-> haddr[3:0] != 4'hc)
    else $error("descriptor fourth word accessed");
  a_desc_primary: assert property (dsc |-> !haddr[7])
    else $error("alternate structure addressed");
  a_desc_ro: assert property (nsq && hwrite |-> haddr[31:8] != base_q)
    else $error("descriptor area written");
  a_desc_word: assert property (dsc |-> hsize == {1'b0, `DMADE_SIZE_WORD})
    else $error("descriptor word not fetched as a full word");
  // Only single plain data beats are issued; a stray burst would upset the slave.
  a_beat_plain: assert property (htrans == `DMADE_HTRANS_NONSEQ |->
    hburst == `DMADE_HBURST_SINGLE && hprot == `DMADE_HPROT_DATA)
    else $error("bus beat not a single data access");
  a_alt_base: assert property (acc && !pwrite && paddr == `DMADE_OFS_ALT_BASE
    |-> prdata == {base_q, 8'h80})
    else $error("alternate base read wrong");
  a_base_read: assert property (acc && !pwrite && paddr == `DMADE_OFS_DESC_BASE
    |-> prdata == {base_q, 8'h00})
    else $error("descriptor base read wrong");
endmodule // dmade_sva

bind dmade_core dmade_sva #(.NCH(NCH)) i_dmade_sva (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hburst(hburst),
  .hprot(hprot), .hwdata(hwdata), .hrdata(hrdata), .hready(hready), .hresp(hresp),
  .channel_done(channel_done), .transfer_error(transfer_error));
`default_nettype wire

// file: tb.sv
// Self-checking bench: APB software model, memory partner, queued results.
// Assumes dmade_core, dmade_mem and the checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "dmade_defines.svh"

module tb;
  `define DMADE_CMP(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
  logic        pclk, presetn, psel, penable, pwrite, slow, pend;
  logic [7:0]  paddr;
  logic [31:0] pwdata, base, err_addr;
  logic [33:0] waddr;
  wire  [31:0] prdata, haddr, hwdata, hrdata;
  wire  [2:0]  hsize;
  wire  [7:0]  channel_done;
  wire  [1:0]  htrans;
  wire         pready, pslverr, hwrite, hready, hresp, transfer_error;
  int          failures, checks, cyc, seed;
  logic [32:0] rq[$];
  logic [65:0] wq[$];

  dmade_core i_dmade_core (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hburst(), .hprot(), .hwdata(hwdata), .hrdata(hrdata), .hready(hready), .hresp(hresp),
    .channel_done(channel_done), .transfer_error(transfer_error));
  dmade_mem i_dmade_mem (.pclk(pclk), .presetn(presetn), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .slow(slow), .err_addr(err_addr), .hrdata(hrdata),
    .hready(hready), .hresp(hresp));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Hang guard; a run needs a few thousand cycles at most.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      complete_run();
    end
  end

  // Outputs are compared at the rising edge that takes them, so the values seen
  // are exactly those the edge samples, before any update lands.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      `DMADE_CMP({pslverr, prdata}, rq.pop_front())
    end
    if (pend && hready) begin
      `DMADE_CMP({waddr, hwdata}, wq.pop_front())
      pend = 1'b0;
    end
    if (htrans == `DMADE_HTRANS_NONSEQ && hready) begin
      pend = hwrite;
      waddr = {hsize[1:0], haddr};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count is assumed; only the bench timeout ends a hung wait.
    do @(posedge pclk); while (!pready);
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // One channel run; err 0 completes, 1 meets a bus error, 2 a reserved code.
  task automatic run(input int ch, input logic [1:0] sz, input logic [1:0] di,
                     input int n, input int err);
    logic [31:0] d, s, e, sa, da;
    int k;
    d = base + 32'(ch) * 32'h10;
    s = 32'h100 + 32'(ch) * 32'h20;
    e = 32'h300 + 32'(ch) * 32'h20;
    i_dmade_mem.mem[d[11:2]] = s;
    i_dmade_mem.mem[d[11:2] + 1] = e;
    i_dmade_mem.mem[d[11:2] + 2] = {di, sz, sz, sz, 10'h0, 10'(n - 1), 4'h1};
    for (k = 0; err == 0 && k < n; k++) begin
      sa = s - (32'(n - 1 - k) << sz);
      da = (di == `DMADE_INC_FIXED) ? e : e - (32'(n - 1 - k) << di);
      wq.push_back({sz, da, {4{sa[9:2] ^ 8'h5a}}});
    end
    slow <= 1'($random(seed));
    err_addr <= (err == 1) ? s : 32'h0;
    apb(1'b1, `DMADE_OFS_CHEN_SET, 32'h1 << ch);
    apb(1'b1, `DMADE_OFS_SW_REQ, 32'h1 << ch);
    do @(posedge pclk); while (!channel_done[ch] && !transfer_error);
    `DMADE_CMP(32'(wq.size()), 32'h0)
    `DMADE_CMP(transfer_error, 1'(err != 0))
    rd(`DMADE_OFS_CHEN_SET, 33'h0);
    rd(`DMADE_OFS_DONE, (err == 0) ? 33'h1 << ch : 33'h0);
    rd(`DMADE_OFS_ERROR, 33'(err));
    apb(1'b1, `DMADE_OFS_DONE, 32'hff);
    apb(1'b1, `DMADE_OFS_ERROR, 32'h3);
    // The clearing write lands at the edge the task returns on; look one edge later.
    @(posedge pclk);
    `DMADE_CMP(transfer_error, 1'b0)
  endtask

  task automatic complete_run();
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 41390;
    {psel, penable, pwrite, slow, pend, paddr, pwdata, err_addr} = '0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DMADE_OFS_STATUS, 33'h0);
    rd(`DMADE_OFS_DESC_BASE, 33'h0);
    rd(`DMADE_OFS_ALT_BASE, 33'h80);
    rd(8'h04, {1'b1, 32'h0});
    base = 32'h400 | {22'h0, 2'($random(seed)), 8'h00};
    apb(1'b1, `DMADE_OFS_DESC_BASE, base | {24'h0, 8'($random(seed))});
    apb(1'b1, `DMADE_OFS_ALT_BASE, 32'hffffffff);
    rd(`DMADE_OFS_DESC_BASE, {1'b0, base});
    rd(`DMADE_OFS_ALT_BASE, {1'b0, base | 32'h80});
    run(3, 2'h0, 2'h0, 3, 0);
    run(5, 2'h0, 2'h1, 2, 0);
    run(6, 2'h0, 2'h2, 2, 0);
    run(1, 2'h1, 2'h1, 2, 0);
    run(7, 2'h2, 2'h2, 2, 0);
    run(2, 2'h2, 2'h3, 3, 0);
    run(4, 2'h1, 2'h0, 1, 2);
    run(0, 2'h2, 2'h1, 1, 2);
    run(0, 2'h2, 2'h2, 1, 1);
    complete_run();
  end
endmodule // tb
`default_nettype wire
